//--- rtl/irg_pkg.sv
/*
 * irg_pkg: constants, states and carrier types for the two-wire register
 * slave with its three-pin general purpose port.
 * assumes: one core clock domain; bus and port pins sampled by the core.
 */
// Functional notes
// R1 - direction bit per pin: 0 input, 1 output
// R2 - pwm select bit forces pin 0 input
// R3 - pwm only on pin 0; pins 1-2 plain
// R4 - output pins drive port data bits
// R5 - data read returns sampled pin levels
// R6 - transmitter changes data only while clock low
// R7 - data falling, clock high means start
// R8 - data rising, clock high means stop
// R9 - master alone makes start and stop
// R10 - bus busy from start until stop
// R11 - repeated start restarts address reception
// R12 - eight bits msb first, then acknowledge
// R13 - master clocks every acknowledge pulse
// R14 - sender releases data during acknowledge
// R15 - receiver pulls data low on ninth pulse
// R16 - addressed device acknowledges every received byte
// R17 - first byte: seven-bit address plus direction
// R18 - direction 0 write, 1 read
// R19 - second write byte is register index
// R20 - third write byte is register value
// R21 - write takes effect at last ack rise
// R22 - master reads via index write, repeated start
// R23 - pwm input high turns led on
// R24 - unmatched address: no ack, idle until start
// R25 - read drives register msb first, stop on nack
package irg_pkg;
	// register offsets
	localparam logic [7:0] IRG_PORT_CONTROL_OFS = 8'h06;
	localparam logic [7:0] IRG_PORT_PIN_VALUES_OFS = 8'h07;
	// field positions in port_control
	localparam int IRG_PWM_SEL_BIT = 4;
	localparam int IRG_DIR_MSB = 2;
	// reset values
	localparam logic [7:0] IRG_PORT_CONTROL_RST = 8'h00;
	localparam logic [7:0] IRG_PORT_PIN_VALUES_RST = 8'h00;
	// device address: arbitrary neutral value, not any real part's
	localparam logic [6:0] IRG_DEV_ADDR = 7'h2A;
	// bits per byte on the serial line
	localparam logic [3:0] IRG_BYTE_BITS = 4'h8;

	// slave sequencer, gray coded along receive path
	typedef enum logic [2:0] {
		IRG_IDLE = 3'b000,
		IRG_ADDR = 3'b001,
		IRG_ACK = 3'b011,
		IRG_RXB = 3'b010,
		IRG_TXB = 3'b110,
		IRG_RACK = 3'b111
	} irg_state_t;

	// sampled bus lines
	typedef struct packed {
		logic scl;
		logic sda;
	} irg_bus_t;

	// received byte handed to the register stage
	typedef struct packed {
		logic is_index;
		logic [7:0] data;
	} irg_word_t;
endpackage : irg_pkg

//--- rtl/irg_slave.sv
/*
 * irg_fifo and irg_slave: two-wire register slave with a three-pin port.
 * assumes: bus clock far slower than core_clk_in (40 MHz, 25 ns);
 * pins arrive asynchronously; pad logic combines the enables into wires.
 */
`timescale 1ns/1ps

// small flip-flop fifo between byte receiver and register file
module irg_fifo #(
	parameter int WIDTH = 9,
	parameter int DEPTH = 32
) (
	input wire logic core_clk_in,
	input wire logic sys_rst_in,
	input wire logic clk_en_in,
	input wire logic in_valid_in,
	output logic in_ready_out,
	input wire logic [WIDTH-1:0] in_data_in,
	output logic out_valid_out,
	input wire logic out_ready_in,
	output logic [WIDTH-1:0] out_data_out
);
	localparam int AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem_reg [DEPTH];
	logic [AW:0] wr_reg; // write pointer with wrap bit
	logic [AW:0] rd_reg; // read pointer with wrap bit
	wire logic full_w = (wr_reg[AW] != rd_reg[AW]) && (wr_reg[AW-1:0] == rd_reg[AW-1:0]);
	wire logic empty_w = (wr_reg == rd_reg);
	wire logic push_w = in_valid_in && !full_w;
	wire logic pop_w = out_ready_in && !empty_w;
	assign in_ready_out = !full_w;
	assign out_valid_out = !empty_w;
	assign out_data_out = mem_reg[rd_reg[AW-1:0]];

	// the wrap bit tells full from empty, so no separate count is kept
	// pointers advance only on accepted handshakes
	always_ff @(posedge core_clk_in) begin
		if (sys_rst_in) begin
			wr_reg <= '0;
			rd_reg <= '0;
		end else if (clk_en_in) begin
			if (push_w) wr_reg <= wr_reg + 1'b1;
			if (pop_w) rd_reg <= rd_reg + 1'b1;
		end
	end

	// trade-off: flip-flop storage costs area but needs no memory macro
	// storage has no reset; it is only read behind valid
	always_ff @(posedge core_clk_in) begin
		if (clk_en_in && push_w) mem_reg[wr_reg[AW-1:0]] <= in_data_in;
	end
endmodule : irg_fifo

module irg_slave #(
	parameter int FIFO_DEPTH = 32
) (
	input wire logic core_clk_in,
	input wire logic sys_rst_in,
	input wire logic clk_en_in,
	input wire logic scl_in, // bus clock pin
	input wire logic sda_in, // bus data pin level
	output logic sda_out, // always low; enable pulls line
	output logic sda_oe_out, // high while device pulls data low
	input wire logic [2:0] pin_in, // port pin levels
	output logic [2:0] pin_out, // port output values
	output logic [2:0] pin_oe_out, // high while device drives pin
	output logic pwm_led_on_out, // external pwm request to led driver
	output logic bus_busy_out // between start and stop
);
	// three-stage synchronisers; decisions use stages two and three
	logic [2:0] scl_sync_reg;
	logic [2:0] sda_sync_reg;
	logic [2:0] pin_s1_reg, pin_s2_reg, pin_s3_reg;
	logic [2:0] pin_lvl_reg; // filtered pin level, moves once stages two and three agree
	irg_pkg::irg_bus_t bus_now, bus_old;
	assign bus_now = '{scl: scl_sync_reg[1], sda: sda_sync_reg[1]};
	assign bus_old = '{scl: scl_sync_reg[2], sda: sda_sync_reg[2]};

	// edges seen once stage two and three disagree
	wire logic scl_rise_w = bus_now.scl && !bus_old.scl;
	wire logic scl_fall_w = !bus_now.scl && bus_old.scl;
	// start and stop need the clock high at both stages, so skew on a clock edge is not taken
	wire logic start_w = bus_now.scl && bus_old.scl && !bus_now.sda && bus_old.sda; // [R7]
	wire logic stop_w = bus_now.scl && bus_old.scl && bus_now.sda && !bus_old.sda; // [R8]

	irg_pkg::irg_state_t state_reg, state_next;
	logic [3:0] bit_cnt_reg; // bits of current byte
	logic [7:0] shift_reg; // byte being shifted
	logic rw_reg; // 1 for read transfer
	logic got_index_reg; // index byte already taken
	logic [7:0] index_reg; // selected register
	logic [7:0] ctrl_reg; // port_control
	logic [7:0] data_reg; // port_pin_values output bits
	logic sda_low_reg; // drive data low
	logic busy_reg;
	logic push_reg; // pulse: byte into fifo
	irg_pkg::irg_word_t push_word_reg;

	wire logic addr_hit_w = (shift_reg[7:1] == irg_pkg::IRG_DEV_ADDR); // [R17]
	wire logic byte_done_w = (bit_cnt_reg == irg_pkg::IRG_BYTE_BITS);
	wire logic [7:0] rd_value_w = read_mux(index_reg, ctrl_reg, pin_lvl_reg);

	// read selection used by both loading and reloading of the shifter
	function automatic logic [7:0] read_mux(input logic [7:0] idx, input logic [7:0] ctl,
			input logic [2:0] pins);
		if (idx == irg_pkg::IRG_PORT_CONTROL_OFS) return ctl;
		else if (idx == irg_pkg::IRG_PORT_PIN_VALUES_OFS) return {5'h00, pins}; // [R5]
		// unknown offsets read as zero, so a stray read shows no stale data
		else return 8'h00;
	endfunction : read_mux

	// fifo carries received index and data bytes to the register file;
	// the drain side stalls only while clk_en_in is low, when pushes stop too, so it never really fills
	logic fifo_ready, fifo_valid, fifo_pop;
	irg_pkg::irg_word_t fifo_word;
	irg_fifo #(.WIDTH(9), .DEPTH(FIFO_DEPTH)) u_fifo (
		.core_clk_in(core_clk_in),
		.sys_rst_in(sys_rst_in),
		.clk_en_in(clk_en_in),
		.in_valid_in(push_reg),
		.in_ready_out(fifo_ready),
		.in_data_in(push_word_reg),
		.out_valid_out(fifo_valid),
		.out_ready_in(fifo_pop),
		.out_data_out(fifo_word)
	);
	// drain every cycle; the register file takes one word per edge
	assign fifo_pop = fifo_valid;

	// synchroniser chain
	// reset to the idle-high bus levels keeps a false start away after reset
	always_ff @(posedge core_clk_in) begin
		if (sys_rst_in) begin
			scl_sync_reg <= 3'h7;
			sda_sync_reg <= 3'h7;
			pin_s1_reg <= 3'h0;
			pin_s2_reg <= 3'h0;
			pin_s3_reg <= 3'h0;
			pin_lvl_reg <= 3'h0;
		end else if (clk_en_in) begin
			scl_sync_reg <= {scl_sync_reg[1:0], scl_in};
			sda_sync_reg <= {sda_sync_reg[1:0], sda_in};
			pin_s1_reg <= pin_in;
			pin_s2_reg <= pin_s1_reg;
			pin_s3_reg <= pin_s2_reg;
			// only the second stage feeds from the first; the level waits for agreement
			pin_lvl_reg <= (pin_s3_reg == pin_s2_reg) ? pin_s3_reg : pin_lvl_reg;
		end
	end

	// next state: start from any state restarts address reception
	// a stop in any state returns to idle, so a cut frame leaves nothing half done
	always_comb begin
		state_next = state_reg;
		if (start_w) state_next = irg_pkg::IRG_ADDR; // [R11]
		else if (stop_w) state_next = irg_pkg::IRG_IDLE;
		else begin
			case (state_reg)
				irg_pkg::IRG_ADDR, irg_pkg::IRG_RXB: begin
					if (scl_fall_w && byte_done_w) begin
						if (state_reg == irg_pkg::IRG_ADDR && !addr_hit_w)
							state_next = irg_pkg::IRG_IDLE; // [R24]
						else
							state_next = irg_pkg::IRG_ACK;
					end
				end
				// ninth pulse: afterwards a read goes on to send, a write to receive
				irg_pkg::IRG_ACK: begin
					if (scl_fall_w) state_next = rw_reg ? irg_pkg::IRG_TXB : irg_pkg::IRG_RXB; // [R18]
				end
				irg_pkg::IRG_TXB: begin
					if (scl_fall_w && byte_done_w) state_next = irg_pkg::IRG_RACK;
				end
				irg_pkg::IRG_RACK: begin
					// master ack continues, nack ends driving
					if (scl_rise_w && bus_now.sda) state_next = irg_pkg::IRG_IDLE; // [R25]
					else if (scl_fall_w) state_next = irg_pkg::IRG_TXB;
				end
				default: state_next = state_reg;
			endcase
		end
	end

	// sequencer registers
	// the branches below are keyed on distinct states or clock edges
	always_ff @(posedge core_clk_in) begin
		if (sys_rst_in) begin
			state_reg <= irg_pkg::IRG_IDLE;
			bit_cnt_reg <= 4'h0;
			shift_reg <= 8'h00;
			rw_reg <= 1'b0;
			got_index_reg <= 1'b0;
			sda_low_reg <= 1'b0;
			busy_reg <= 1'b0;
			push_reg <= 1'b0;
			push_word_reg <= '0;
		end else if (clk_en_in) begin
			state_reg <= state_next;
			push_reg <= 1'b0;
			if (start_w) busy_reg <= 1'b1; // [R10]
			else if (stop_w) busy_reg <= 1'b0;
			if (start_w) begin
				bit_cnt_reg <= 4'h0;
				got_index_reg <= 1'b0;
				sda_low_reg <= 1'b0;
			end else if (stop_w) begin
				sda_low_reg <= 1'b0;
			end else begin
				// receiving: sample on rise, msb first
				if ((state_reg == irg_pkg::IRG_ADDR || state_reg == irg_pkg::IRG_RXB)
						&& scl_rise_w) begin
					shift_reg <= {shift_reg[6:0], bus_now.sda}; // [R12]
					bit_cnt_reg <= bit_cnt_reg + 4'h1;
				end
				// transmitting: change data on fall only, msb first
				if (state_reg == irg_pkg::IRG_TXB && scl_fall_w) begin
					sda_low_reg <= byte_done_w ? 1'b0 : !shift_reg[7]; // [R6] [R14]
					shift_reg <= {shift_reg[6:0], 1'b0};
					bit_cnt_reg <= bit_cnt_reg + 4'h1;
				end
				// byte received: pull data low for the ninth pulse
				if ((state_reg == irg_pkg::IRG_ADDR || state_reg == irg_pkg::IRG_RXB)
						&& scl_fall_w && byte_done_w) begin
					bit_cnt_reg <= 4'h0;
					if (state_reg == irg_pkg::IRG_ADDR) begin
						sda_low_reg <= addr_hit_w; // [R15] [R16]
						rw_reg <= shift_reg[0];
					end else begin
						sda_low_reg <= fifo_ready; // refuse ack only when the fifo is full
						push_reg <= fifo_ready;
						push_word_reg <= '{is_index: !got_index_reg, data: shift_reg}; // [R19]
						got_index_reg <= 1'b1;
					end
				end
				// end of ack pulse: release, or load read byte and drive its msb
				if (state_reg == irg_pkg::IRG_ACK && scl_fall_w) begin
					if (rw_reg) begin
						shift_reg <= {rd_value_w[6:0], 1'b0};
						sda_low_reg <= !rd_value_w[7]; // [R25]
						bit_cnt_reg <= 4'h1;
					end else begin
						sda_low_reg <= 1'b0;
					end
				end
				// limitation: a read never moves on to the next register
				// master ack: reload next byte of the same register
				if (state_reg == irg_pkg::IRG_RACK && scl_fall_w) begin
					shift_reg <= {rd_value_w[6:0], 1'b0};
					sda_low_reg <= !rd_value_w[7];
					bit_cnt_reg <= 4'h1;
				end
			end
		end
	end

	// register file: index then data; data is written only once the
	// last ack rising edge has been seen, so a stop mid-byte changes nothing
	// pending data waits here for the commit edge
	logic [7:0] pend_data_reg;
	logic pend_reg;
	// only write transfers commit; a read ack never touches the registers
	wire logic ack_rise_w = (state_reg == irg_pkg::IRG_ACK) && scl_rise_w && !rw_reg;
	// a write into an unmapped index is dropped; reads of it give zero
	always_ff @(posedge core_clk_in) begin
		if (sys_rst_in) begin
			index_reg <= 8'h00;
			ctrl_reg <= irg_pkg::IRG_PORT_CONTROL_RST;
			data_reg <= irg_pkg::IRG_PORT_PIN_VALUES_RST;
			pend_reg <= 1'b0;
			pend_data_reg <= 8'h00;
		end else if (clk_en_in) begin
			if (fifo_valid) begin
				if (fifo_word.is_index) index_reg <= fifo_word.data;
				else begin
					pend_reg <= 1'b1;
					pend_data_reg <= fifo_word.data; // [R20]
				end
			end
			// data left over from a frame cut before its ack must not be
			// committed at the first ack of the next frame
			if (start_w || stop_w) pend_reg <= 1'b0;
			if (ack_rise_w && pend_reg && !fifo_valid) begin
				pend_reg <= 1'b0;
				if (index_reg == irg_pkg::IRG_PORT_CONTROL_OFS) ctrl_reg <= pend_data_reg; // [R21]
				else if (index_reg == irg_pkg::IRG_PORT_PIN_VALUES_OFS) data_reg <= pend_data_reg;
			end
		end
	end

	// pin drive: pwm select overrides pin 0 direction
	// pin_out carries data bits 2:0 whatever the direction; the enable alone decides what reaches a pin
	wire logic pwm_sel_w = ctrl_reg[irg_pkg::IRG_PWM_SEL_BIT];
	wire logic [2:0] dir_w = ctrl_reg[irg_pkg::IRG_DIR_MSB:0]; // [R1]
	assign pin_oe_out = {dir_w[2:1], dir_w[0] && !pwm_sel_w}; // [R2] [R3]
	assign pin_out = data_reg[2:0]; // [R4]
	assign pwm_led_on_out = pwm_sel_w && pin_lvl_reg[0]; // [R23]
	// open drain: the value is always low, only the enable moves the wire
	assign sda_out = 1'b0;
	assign sda_oe_out = sda_low_reg;
	assign bus_busy_out = busy_reg;

	// checks: each guards one rule on the core clock, quiet during reset
	// they watch the sequencer and register file, not the bench's pins
	a_start_busy: assert property (@(posedge core_clk_in) disable iff (sys_rst_in) // [R10]
		clk_en_in && start_w |=> busy_reg) else $error("busy not set by start");
	a_busy_free: assert property (@(posedge core_clk_in) disable iff (sys_rst_in) // [R10]
		clk_en_in && !start_w && !stop_w |=> $stable(busy_reg))
		else $error("busy moved without start or stop");
	a_stop_idle: assert property (@(posedge core_clk_in) disable iff (sys_rst_in) // [R8]
		clk_en_in && stop_w |=> state_reg == irg_pkg::IRG_IDLE && !busy_reg)
		else $error("stop did not end session");
	a_restart_addr: assert property (@(posedge core_clk_in) disable iff (sys_rst_in) // [R11]
		clk_en_in && start_w |=> state_reg == irg_pkg::IRG_ADDR && bit_cnt_reg == 4'h0)
		else $error("start did not restart address");
	a_pwm_pin_input: assert property (@(posedge core_clk_in) disable iff (sys_rst_in) // [R2]
		pwm_sel_w |-> !pin_oe_out[0]) else $error("pin 0 driven in pwm mode");
	a_sda_steady_high: assert property (@(posedge core_clk_in) disable iff (sys_rst_in) // [R6]
		clk_en_in && bus_now.scl && bus_old.scl && !start_w && !stop_w |=> $stable(sda_low_reg))
		else $error("data changed while clock high");
	a_nohit_noack: assert property (@(posedge core_clk_in) disable iff (sys_rst_in) // [R24]
		clk_en_in && state_reg == irg_pkg::IRG_ADDR && scl_fall_w && byte_done_w
		&& !addr_hit_w && !start_w && !stop_w |=> !sda_low_reg && state_reg == irg_pkg::IRG_IDLE)
		else $error("acked foreign address");
	a_idle_quiet: assert property (@(posedge core_clk_in) disable iff (sys_rst_in) // [R24]
		state_reg == irg_pkg::IRG_IDLE |-> !sda_low_reg) else $error("data pulled while idle");
	a_ack_hit: assert property (@(posedge core_clk_in) disable iff (sys_rst_in) // [R16]
		clk_en_in && state_reg == irg_pkg::IRG_ADDR && scl_fall_w && byte_done_w
		&& addr_hit_w && !start_w && !stop_w |=> sda_low_reg)
		else $error("no ack for own address");
	a_tx_release: assert property (@(posedge core_clk_in) disable iff (sys_rst_in) // [R14]
		clk_en_in && state_reg == irg_pkg::IRG_TXB && scl_fall_w && byte_done_w
		&& !start_w && !stop_w |=> !sda_low_reg && state_reg == irg_pkg::IRG_RACK)
		else $error("data held after the eighth read bit");
	a_rack_released: assert property (@(posedge core_clk_in) disable iff (sys_rst_in) // [R14]
		state_reg == irg_pkg::IRG_RACK |-> !sda_low_reg) else $error("data pulled in master ack");
	a_write_late: assert property (@(posedge core_clk_in) disable iff (sys_rst_in) // [R21]
		clk_en_in && !ack_rise_w |=> $stable(ctrl_reg) && $stable(data_reg))
		else $error("register changed outside last ack");
	a_pwm_follow: assert property (@(posedge core_clk_in) disable iff (sys_rst_in) // [R23]
		!pwm_sel_w |-> !pwm_led_on_out) else $error("pwm active while disabled");
	// coverage of the main scenarios
	c_write_ctrl: cover property (@(posedge core_clk_in) ack_rise_w && pend_reg);
	c_read_byte: cover property (@(posedge core_clk_in) state_reg == irg_pkg::IRG_RACK);
	c_restart: cover property (@(posedge core_clk_in) start_w && busy_reg);
	c_foreign: cover property (@(posedge core_clk_in)
		state_reg == irg_pkg::IRG_ADDR && scl_fall_w && byte_done_w && !addr_hit_w);
	c_pwm_on: cover property (@(posedge core_clk_in) pwm_led_on_out);
endmodule : irg_slave

//--- verification/irg_host_model.sv
/*
 * irg_host_model: two-wire bus master that stands at the far side of the slave.
 * assumes: open-drain data wire with pull-up resolved by the bench; bit rate 200 ns.
 */
`timescale 1ns/1ps
module irg_host_model (
	output logic scl_out, // bus clock, idles high between frames
	output logic sda_low_out, // high while the master pulls data low
	input wire logic sda_in // resolved data wire
);
	logic ack_slot; // high through the acknowledge pulse of each byte written by wbyte
	initial begin
		scl_out = 1'b1;
		sda_low_out = 1'b0;
		ack_slot = 1'b0;
	end
	// one bit: data set mid low phase, sampled late in high phase
	task automatic bit_slot(input logic b, output logic seen);
		#50 sda_low_out = ~b;
		#50 scl_out = 1'b1;
		#90 seen = sda_in;
		#10 scl_out = 1'b0;
	endtask : bit_slot
	// start or repeated start; only the master makes these
	task automatic start();
		// wait for the slave to let go of its ack before the clock rises
		#50 sda_low_out = 1'b0;
		#50 scl_out = 1'b1;
		#50 sda_low_out = 1'b1;
		#50 scl_out = 1'b0;
	endtask : start
	// stop ends the session and leaves both lines released
	task automatic stop();
		#50 sda_low_out = 1'b1;
		#50 scl_out = 1'b1;
		#50 sda_low_out = 1'b0;
		#50;
	endtask : stop
	// eight bits msb first, data released for the slave's ack
	task automatic wbyte(input logic [7:0] d, output logic ack);
		logic s;
		for (int i = 7; i >= 0; i--) begin
			bit_slot(d[i], s);
		end
		ack_slot = 1'b1;
		bit_slot(1'b1, ack);
		ack_slot = 1'b0;
	endtask : wbyte
	// read a byte, then pull low on the ninth pulse only to ask for more
	task automatic rbyte(input logic more, output logic [7:0] d);
		logic s;
		for (int i = 7; i >= 0; i--) begin
			bit_slot(1'b1, d[i]);
		end
		bit_slot(~more, s);
	endtask : rbyte
endmodule : irg_host_model

//--- verification/tb_irg_slave.sv
/*
 * tb_irg_slave: self-checking bench for the register slave and its port.
 * assumes: host model drives the bus; bench plays the outside pin loads.
 */
`timescale 1ns/1ps
module tb_irg_slave;
	localparam logic [7:0] WAD = {irg_pkg::IRG_DEV_ADDR, 1'b0};
	localparam logic [7:0] RAD = {irg_pkg::IRG_DEV_ADDR, 1'b1};
	localparam logic [7:0] CTL = irg_pkg::IRG_PORT_CONTROL_OFS;
	localparam logic [7:0] DAT = irg_pkg::IRG_PORT_PIN_VALUES_OFS;
	typedef struct packed {
		logic [7:0] ctrl; // control value written
		logic [7:0] data; // port data written
		logic [2:0] ext; // level driven from outside on input pins
		logic [2:0] oe; // expected drive enables
		logic [7:0] lvl; // expected read of pin values
		logic pwm; // expected led request
	} irg_row_t;
	logic core_clk_in = 1'b0;
	logic sys_rst_in = 1'b1;
	logic [2:0] ext = 3'h0; // outside pin loads
	logic clk_en = 1'b1; // core clock enable
	logic scl; // bus clock from host
	logic m_low; // host pulling data
	logic sda_out;
	logic sda_oe_out;
	logic [2:0] pin_out;
	logic [2:0] pin_oe_out;
	logic pwm_led_on_out;
	logic bus_busy_out;
	wire logic sda_w; // pulled-up open-drain data wire
	wire logic [2:0] pin_w; // each pin follows its driver
	int n_mismatch = 0;
	int tests_run = 0;
	logic [7:0] v;
	irg_row_t rows [5];
	assign sda_w = (sda_oe_out ? sda_out : 1'b1) & ~m_low;
	assign pin_w = (pin_oe_out & pin_out) | (~pin_oe_out & ext);
	irg_slave #(.FIFO_DEPTH(32)) u_irg_slave (.core_clk_in(core_clk_in),
		.sys_rst_in(sys_rst_in), .clk_en_in(clk_en), .scl_in(scl), .sda_in(sda_w),
		.sda_out(sda_out), .sda_oe_out(sda_oe_out), .pin_in(pin_w),
		.pin_out(pin_out), .pin_oe_out(pin_oe_out),
		.pwm_led_on_out(pwm_led_on_out), .bus_busy_out(bus_busy_out));
	irg_host_model u_irg_host_model (.scl_out(scl), .sda_low_out(m_low),
		.sda_in(sda_w));
	// 40 MHz core clock
	initial begin
		forever #12.5 core_clk_in = ~core_clk_in;
	end
	task automatic report_and_stop();
		$display("compares %0d mismatches %0d", tests_run, n_mismatch);
		if (n_mismatch == 0 && tests_run > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask : report_and_stop
	task automatic check(input logic [7:0] seen, input logic [7:0] exp, input string what);
		tests_run++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("[ERR] %0t %s: got %h want %h", $time, what, seen, exp);
		end
	endtask : check
	// step n edges, then land just after the edge
	task automatic tick(input int n);
		repeat (n) @(posedge core_clk_in);
		#1;
	endtask : tick
	// send one byte and expect the slave to acknowledge it
	task automatic send(input logic [7:0] b);
		logic a;
		u_irg_host_model.wbyte(b, a);
		check({7'h00, a}, 8'h00, "ack");
	endtask : send
	task automatic wr(input logic [7:0] idx, input logic [7:0] val);
		u_irg_host_model.start();
		send(WAD);
		send(idx);
		send(val);
		u_irg_host_model.stop();
	endtask : wr
	// index write, repeated start, then one byte closed by a nack
	task automatic rd(input logic [7:0] idx, output logic [7:0] d);
		u_irg_host_model.start();
		send(WAD);
		send(idx);
		u_irg_host_model.start();
		send(RAD);
		u_irg_host_model.rbyte(1'b0, d);
		u_irg_host_model.stop();
	endtask : rd
	initial begin
		int k;
		int guard;
		logic prev;
		rows[0] = '{8'hE7, 8'h05, 3'h0, 3'h7, 8'h05, 1'b0};
		rows[1] = '{8'h10, 8'h03, 3'h1, 3'h0, 8'h01, 1'b1};
		rows[2] = '{8'h17, 8'h06, 3'h0, 3'h6, 8'h06, 1'b0};
		rows[3] = '{8'h02, 8'h07, 3'h5, 3'h2, 8'h07, 1'b0};
		rows[4] = '{8'h15, 8'h04, 3'h1, 3'h4, 8'h05, 1'b1};
		tick(4);
		sys_rst_in = 1'b0;
		tick(4);
		check({5'h00, pin_oe_out}, 8'h00, "oe reset");
		check({7'h00, sda_out}, 8'h00, "sda value");
		rd(CTL, v);
		check(v, irg_pkg::IRG_PORT_CONTROL_RST, "ctrl reset");
		// table of port settings against pin behaviour
		foreach (rows[i]) begin
			ext = rows[i].ext;
			wr(CTL, rows[i].ctrl);
			wr(DAT, rows[i].data);
			tick(8);
			check({5'h00, pin_oe_out}, {5'h00, rows[i].oe}, "dir");
			check({5'h00, pin_out}, {5'h00, rows[i].data[2:0]}, "out");
			check({7'h00, pwm_led_on_out}, {7'h00, rows[i].pwm}, "pwm");
			rd(DAT, v);
			check(v, rows[i].lvl, "levels");
			rd(CTL, v);
			check(v, rows[i].ctrl, "ctrl");
		end
		// new control must not land before the last acknowledge rises
		k = 0;
		guard = 0;
		prev = 1'b0;
		fork
			wr(CTL, 8'h03);
			begin
				while (k < 3 && guard < 4000) begin
					@(posedge core_clk_in);
					guard++;
					if (u_irg_host_model.ack_slot && !prev) k++;
					prev = u_irg_host_model.ack_slot;
				end
				if (k < 3) begin
					n_mismatch++;
					report_and_stop();
				end
				#1;
				check({5'h00, pin_oe_out}, 8'h04, "early");
			end
		join
		tick(8);
		check({5'h00, pin_oe_out}, 8'h03, "late");
		// busy between start and stop
		u_irg_host_model.start();
		tick(6);
		check({7'h00, bus_busy_out}, 8'h01, "busy");
		u_irg_host_model.stop();
		tick(6);
		check({7'h00, bus_busy_out}, 8'h00, "free");
		// foreign address: no ack, later bytes ignored
		u_irg_host_model.start();
		u_irg_host_model.wbyte(WAD ^ 8'h02, prev);
		check({7'h00, prev}, 8'h01, "foreign");
		u_irg_host_model.wbyte(CTL, prev);
		check({7'h00, prev}, 8'h01, "ignored");
		u_irg_host_model.stop();
		// unmapped index: write dropped, read gives zero
		wr(8'h00, 8'hFF);
		rd(8'h00, v);
		check(v, 8'h00, "unmapped");
		// two-byte read, then released after the nack
		u_irg_host_model.start();
		send(WAD);
		send(CTL);
		u_irg_host_model.start();
		send(RAD);
		u_irg_host_model.rbyte(1'b1, v);
		check(v, 8'h03, "rd1");
		u_irg_host_model.rbyte(1'b0, v);
		check(v, 8'h03, "rd2");
		check({7'h00, sda_oe_out}, 8'h00, "release");
		u_irg_host_model.stop();
		// frozen core ignores a whole start and stop
		tick(1);
		clk_en = 1'b0;
		u_irg_host_model.start();
		tick(4);
		check({7'h00, bus_busy_out}, 8'h00, "frozen");
		u_irg_host_model.stop();
		tick(1);
		clk_en = 1'b1;
		tick(6);
		check({7'h00, bus_busy_out}, 8'h00, "thawed");
		// reset again in mid-run
		tick(1);
		sys_rst_in = 1'b1;
		tick(2);
		sys_rst_in = 1'b0;
		tick(4);
		check({5'h00, pin_oe_out}, 8'h00, "oe rst2");
		check({5'h00, pin_out}, 8'h00, "out rst2");
		check({7'h00, bus_busy_out}, 8'h00, "busy rst2");
		rd(CTL, v);
		check(v, irg_pkg::IRG_PORT_CONTROL_RST, "ctrl rst2");
		report_and_stop();
	end
endmodule : tb_irg_slave
